/* common/sram_link_pkg.sv */
// Shared constants and types for the burst SRAM link.
`default_nettype none
package sram_link_pkg;
   // Sleep pin passes a two-stage synchroniser: entry takes this many cycles.
   localparam int SLEEP_ENTRY_CYCLES    = 2;
   localparam int SLEEP_RECOVERY_CYCLES = 2;
   localparam int WAKE_CNT_W            = 2;
   localparam int BURST_LOW_W           = 2;
   localparam logic FT_PIN_DEFAULT      = 1'b1;
   localparam logic SLEEP_PIN_DEFAULT   = 1'b0;
   localparam logic ORDER_PIN_RESET     = 1'b0;
   localparam logic [1:0] BURST_FIRST   = 2'h0;
   localparam logic [1:0] BURST_STEP    = 2'h1;

   typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} op_t;
   typedef enum logic [1:0] {PWR_ACTIVE, PWR_ASLEEP, PWR_WAKE} pwr_t;
   typedef enum logic [2:0] {H_RUN, H_DRAIN, H_SLEEP, H_QUIET, H_RECOVER} hpwr_t;
endpackage : sram_link_pkg
`default_nettype wire

/* common/sram_link_if.sv */
// Pin bundle between the memory controller and the SRAM, with pin resolution.
`timescale 1ns/1ns
`default_nettype none
interface sram_link_if #(
   parameter int ADDR_W = 8,
   parameter int BYTES  = 4,
   parameter int BYTE_W = 9
);
   logic                      cke_n;
   logic                      advance_load;
   logic                      we_n;
   logic                      ce1_n;
   logic                      ce2;
   logic                      ce3_n;
   logic [BYTES-1:0]          byte_we_n;
   logic [ADDR_W-1:0]         addr;
   logic [BYTES*BYTE_W-1:0]   dq;
   logic [BYTES*BYTE_W-1:0]   dq_host_out;
   logic [BYTES*BYTE_W-1:0]   dq_dev_out;
   logic                      dq_host_oe;
   logic                      dq_dev_oe;
   logic                      sleep_drive;
   logic                      sleep_drive_oe;
   logic                      sleep_request;
   logic                      ft_drive;
   logic                      ft_drive_oe;
   logic                      flow_through_select_n;
   logic                      burst_order_select_n;

   // An undriven bus reads as zero; undriven mode pins take their pull values.
   assign dq = dq_dev_oe ? dq_dev_out : (dq_host_oe ? dq_host_out : '0);
   assign sleep_request = sleep_drive_oe ? sleep_drive : sram_link_pkg::SLEEP_PIN_DEFAULT;
   assign flow_through_select_n = ft_drive_oe ? ft_drive : sram_link_pkg::FT_PIN_DEFAULT;

   modport dev (
      input  cke_n, advance_load, we_n, ce1_n, ce2, ce3_n, byte_we_n, addr, dq,
      input  sleep_request, flow_through_select_n, burst_order_select_n,
      output dq_dev_out, dq_dev_oe
   );
   modport host (
      output cke_n, advance_load, we_n, ce1_n, ce2, ce3_n, byte_we_n, addr,
      output dq_host_out, dq_host_oe, sleep_drive, sleep_drive_oe,
      output ft_drive, ft_drive_oe, burst_order_select_n,
      input  dq
   );
endinterface : sram_link_if
`default_nettype wire

/* rtl/burst_addr_gen.sv */
// Two-bit burst address counter with linear or interleaved order.
`timescale 1ns/1ns
`default_nettype none
module burst_addr_gen (
   input  wire logic       clock,
   input  wire logic       arst_n,
   input  wire logic       step_en,
   input  wire logic       load,
   input  wire logic       order_interleaved,
   input  wire logic [1:0] load_low,
   output logic      [1:0] burst_low
);
   logic [1:0] start_reg;
   logic [1:0] index_reg;
   logic [1:0] index_next;

   // The index wraps from 3 to 0, so the fifth access repeats the first.
   assign index_next = load ? sram_link_pkg::BURST_FIRST
                            : 2'(index_reg + sram_link_pkg::BURST_STEP);

   always_comb begin
      if (load) begin
         burst_low = load_low;
      end else if (order_interleaved) begin
         burst_low = start_reg ^ index_next;
      end else begin
         burst_low = 2'(start_reg + index_next);
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         start_reg <= sram_link_pkg::BURST_FIRST;
         index_reg <= sram_link_pkg::BURST_FIRST;
      end else if (step_en) begin
         if (load) begin
            start_reg <= load_low;
         end
         index_reg <= index_next;
      end
   end
endmodule : burst_addr_gen
`default_nettype wire

/* rtl/sram_dev_end.sv */
// SRAM end of the link: array, command pipeline, burst address and sleep.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Advance high steps counter, uses counter address.
// - Advance low loads external start address.
// - Burst covers four addresses, fifth wraps.
// - Order pin low linear, high interleaved.
// - Linear order adds one modulo four.
// - Interleaved order XORs start with index.
// - Mode pin low flow-through, else pipelined.
// - Unconnected pins default pipelined and awake.
// - Sleep entered two cycles after request.
// - Wake takes two cycles after request drops.
// - Asleep: ignore inputs, data bus released.
// - Host drains pending operations before sleeping.
// - Host issues no writes during recovery.
// - Host keeps sleep request low normally.
// - Back-to-back commands with no turnaround cycle.
// - Continue cycles ignore write and chip enables.
// - Pipelined read two edges, write third.
// - Clock gate high freezes commands and data; pin synchronisers and sleep state still run.
module sram_dev_end #(
   parameter int ADDR_W = 8,
   parameter int BYTES  = 4,
   parameter int BYTE_W = 9
) (
   input  wire logic clock,
   input  wire logic arst_n,
   sram_link_if.dev  link,
   output logic      sleeping,
   output logic      pipelined
);
   localparam int DW = BYTES * BYTE_W;
   localparam logic [sram_link_pkg::WAKE_CNT_W-1:0] WAKE_CNT_INIT =
      sram_link_pkg::WAKE_CNT_W'(sram_link_pkg::SLEEP_RECOVERY_CYCLES - 1);

   logic                     zz_s1;
   logic                     zz_s2;
   logic                     ft_s1;
   logic                     ft_s2;
   logic                     order_s1;
   logic                     order_s2;
   sram_link_pkg::pwr_t      pwr_reg;
   logic [sram_link_pkg::WAKE_CNT_W-1:0] wake_cnt_reg;
   logic                     asleep;
   logic                     step;
   logic                     selected;
   sram_link_pkg::op_t       op_now;
   sram_link_pkg::op_t       burst_op_reg;
   logic [1:0]               burst_low;
   logic [ADDR_W-1:2]        upper_reg;
   logic [ADDR_W-1:0]        cur_addr;
   sram_link_pkg::op_t       s1_op_reg;
   sram_link_pkg::op_t       s2_op_reg;
   logic [ADDR_W-1:0]        s1_addr_reg;
   logic [ADDR_W-1:0]        s2_addr_reg;
   logic [BYTES-1:0]         s1_be_n_reg;
   logic [BYTES-1:0]         s2_be_n_reg;
   sram_link_pkg::op_t       wr_op;
   logic [ADDR_W-1:0]        wr_addr;
   logic [BYTES-1:0]         wr_be_n;
   logic [DW-1:0]            dout_reg;
   logic                     oe_reg;
   logic [DW-1:0]            mem [2**ADDR_W];

   // Sleep and mode pins are asynchronous to the clock.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         zz_s1    <= sram_link_pkg::SLEEP_PIN_DEFAULT;
         zz_s2    <= sram_link_pkg::SLEEP_PIN_DEFAULT;
         ft_s1    <= sram_link_pkg::FT_PIN_DEFAULT;
         ft_s2    <= sram_link_pkg::FT_PIN_DEFAULT;
         order_s1 <= sram_link_pkg::ORDER_PIN_RESET;
         order_s2 <= sram_link_pkg::ORDER_PIN_RESET;
      end else begin
         zz_s1    <= link.sleep_request;
         zz_s2    <= zz_s1;
         ft_s1    <= link.flow_through_select_n;
         ft_s2    <= ft_s1;
         order_s1 <= link.burst_order_select_n;
         order_s2 <= order_s1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pwr_reg      <= sram_link_pkg::PWR_ACTIVE;
         wake_cnt_reg <= '0;
      end else begin
         unique case (pwr_reg)
            sram_link_pkg::PWR_ACTIVE: begin
               if (zz_s2) begin
                  pwr_reg <= sram_link_pkg::PWR_ASLEEP;
               end
            end
            sram_link_pkg::PWR_ASLEEP: begin
               if (!zz_s2) begin
                  pwr_reg      <= sram_link_pkg::PWR_WAKE;
                  wake_cnt_reg <= WAKE_CNT_INIT;
               end
            end
            sram_link_pkg::PWR_WAKE: begin
               if (zz_s2) begin
                  pwr_reg <= sram_link_pkg::PWR_ASLEEP;
               end else if (wake_cnt_reg == '0) begin
                  pwr_reg <= sram_link_pkg::PWR_ACTIVE;
               end else begin
                  wake_cnt_reg <= wake_cnt_reg - 1'b1;
               end
            end
         endcase
      end
   end

   // Sleep blocks the edge as soon as the synchronised request is seen.
   assign asleep   = zz_s2 || (pwr_reg == sram_link_pkg::PWR_ASLEEP);
   assign step     = !link.cke_n && !asleep;
   assign selected = !link.ce1_n && link.ce2 && !link.ce3_n;

   always_comb begin
      if (link.advance_load) begin
         op_now = burst_op_reg;
      end else if (!selected) begin
         op_now = sram_link_pkg::OP_IDLE;
      end else if (link.we_n) begin
         op_now = sram_link_pkg::OP_READ;
      end else begin
         op_now = sram_link_pkg::OP_WRITE;
      end
      // A write arriving while the array recovers is treated as an abort.
      if (pwr_reg == sram_link_pkg::PWR_WAKE && op_now == sram_link_pkg::OP_WRITE) begin
         op_now = sram_link_pkg::OP_IDLE;
      end
   end

   burst_addr_gen u_burst (
      .clock             (clock),
      .arst_n            (arst_n),
      .step_en           (step),
      .load              (!link.advance_load),
      .order_interleaved (order_s2),
      .load_low          (link.addr[1:0]),
      .burst_low         (burst_low)
   );

   assign cur_addr = link.advance_load ? {upper_reg, burst_low} : link.addr;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         upper_reg <= '0;
      end else if (step && !link.advance_load) begin
         upper_reg <= link.addr[ADDR_W-1:2];
      end
   end

   // A new command is taken on every active edge, reads and writes mixed.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         burst_op_reg <= sram_link_pkg::OP_IDLE;
         s1_op_reg    <= sram_link_pkg::OP_IDLE;
         s2_op_reg    <= sram_link_pkg::OP_IDLE;
         s1_addr_reg  <= '0;
         s2_addr_reg  <= '0;
         s1_be_n_reg  <= '1;
         s2_be_n_reg  <= '1;
      end else if (step) begin
         burst_op_reg <= op_now;
         s1_op_reg    <= op_now;
         s1_addr_reg  <= cur_addr;
         s1_be_n_reg  <= link.byte_we_n;
         s2_op_reg    <= s1_op_reg;
         s2_addr_reg  <= s1_addr_reg;
         s2_be_n_reg  <= s1_be_n_reg;
      end
   end

   // Write data lands one edge after the command in flow-through, two when pipelined.
   always_comb begin
      if (ft_s2) begin
         wr_op   = s2_op_reg;
         wr_addr = s2_addr_reg;
         wr_be_n = s2_be_n_reg;
      end else begin
         wr_op   = s1_op_reg;
         wr_addr = s1_addr_reg;
         wr_be_n = s1_be_n_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (step && wr_op == sram_link_pkg::OP_WRITE) begin
         for (int b = 0; b < BYTES; b++) begin
            if (!wr_be_n[b]) begin
               mem[wr_addr][b*BYTE_W +: BYTE_W] <= link.dq[b*BYTE_W +: BYTE_W];
            end
         end
      end
   end

   // A stalled edge leaves the output register and its enable untouched.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dout_reg <= '0;
         oe_reg   <= 1'b0;
      end else if (asleep) begin
         oe_reg <= 1'b0;
      end else if (step) begin
         if (ft_s2) begin
            dout_reg <= mem[s1_addr_reg];
            oe_reg   <= (s1_op_reg == sram_link_pkg::OP_READ);
         end else begin
            dout_reg <= mem[cur_addr];
            oe_reg   <= (op_now == sram_link_pkg::OP_READ);
         end
      end
   end

   assign link.dq_dev_out = dout_reg;
   assign link.dq_dev_oe  = oe_reg;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sleeping  <= 1'b0;
         pipelined <= sram_link_pkg::FT_PIN_DEFAULT;
      end else begin
         sleeping  <= asleep;
         pipelined <= ft_s2;
      end
   end
endmodule : sram_dev_end
`default_nettype wire

/* rtl/sram_host_end.sv */
// Controller end of the link: drives commands, tracks data timing and sleep.
`timescale 1ns/1ns
`default_nettype none
module sram_host_end #(
   parameter int ADDR_W = 8,
   parameter int BYTES  = 4,
   parameter int BYTE_W = 9
) (
   input  wire logic                    clock,
   input  wire logic                    arst_n,
   sram_link_if.host                    link,
   input  wire logic                    cmd_valid,
   input  wire logic                    cmd_write,
   input  wire logic                    cmd_continue,
   input  wire logic [ADDR_W-1:0]       cmd_addr,
   input  wire logic [BYTES*BYTE_W-1:0] cmd_wdata,
   input  wire logic [BYTES-1:0]        cmd_byte_en,
   input  wire logic                    stall_req,
   input  wire logic                    sleep_req,
   input  wire logic                    flow_mode_sel,
   input  wire logic                    order_interleaved,
   input  wire logic                    pins_float,
   output logic                         rd_ready,
   output logic                         wr_ready,
   output logic [BYTES*BYTE_W-1:0]      rd_data,
   output logic                         rd_valid,
   output logic                         sleep_active
);
   localparam int DW = BYTES * BYTE_W;
   localparam logic [1:0] QUIET_INIT = 2'(sram_link_pkg::SLEEP_ENTRY_CYCLES - 1);
   localparam logic [1:0] RECOVER_INIT = 2'(sram_link_pkg::SLEEP_RECOVERY_CYCLES - 1);

   sram_link_pkg::op_t    last_op_reg;
   sram_link_pkg::hpwr_t  hpwr_reg;
   logic [1:0]            cnt_reg;
   logic                  eff_write;
   logic                  accept;
   logic                  accept_rd;
   logic                  accept_wr;
   logic                  ft_mode;
   logic                  empty;
   logic                  cke_n_reg;
   logic                  adv_reg;
   logic                  we_n_reg;
   logic                  ce1_n_reg;
   logic [BYTES-1:0]      be_n_reg;
   logic [ADDR_W-1:0]     addr_reg;
   logic [2:0]            rd_trk_reg;
   logic [1:0]            wr_trk_reg;
   logic [DW-1:0]         wd0_reg;
   logic [DW-1:0]         wd1_reg;
   logic [DW-1:0]         dq_out_reg;
   logic                  dq_oe_reg;
   logic                  ft_pin_reg;
   logic                  pin_oe_reg;
   logic                  order_reg;

   assign ft_mode   = !pins_float && flow_mode_sel;
   assign eff_write = cmd_continue ? (last_op_reg == sram_link_pkg::OP_WRITE) : cmd_write;
   assign accept    = cmd_valid && !stall_req && (eff_write ? wr_ready : rd_ready);
   assign accept_wr = accept && eff_write;
   assign accept_rd = accept && (cmd_continue ? (last_op_reg == sram_link_pkg::OP_READ)
                                              : !cmd_write);
   assign empty     = (rd_trk_reg == '0) && (wr_trk_reg == '0) && !dq_oe_reg;

   // Idle cycles drive a deselect so the next continue starts from a known state.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cke_n_reg   <= 1'b0;
         adv_reg     <= 1'b0;
         we_n_reg    <= 1'b1;
         ce1_n_reg   <= 1'b1;
         be_n_reg    <= '1;
         addr_reg    <= '0;
         last_op_reg <= sram_link_pkg::OP_IDLE;
      end else begin
         cke_n_reg <= stall_req;
         adv_reg   <= accept && cmd_continue;
         we_n_reg  <= !(accept && cmd_write);
         ce1_n_reg <= !accept;
         be_n_reg  <= ~cmd_byte_en;
         addr_reg  <= cmd_addr;
         if (accept && !cmd_continue) begin
            last_op_reg <= cmd_write ? sram_link_pkg::OP_WRITE : sram_link_pkg::OP_READ;
         end else if (!accept && !stall_req) begin
            last_op_reg <= sram_link_pkg::OP_IDLE;
         end
      end
   end

   // Trackers advance only on edges the SRAM does not ignore.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rd_trk_reg <= '0;
         wr_trk_reg <= '0;
         wd0_reg    <= '0;
         wd1_reg    <= '0;
         dq_out_reg <= '0;
         dq_oe_reg  <= 1'b0;
         rd_data    <= '0;
         rd_valid   <= 1'b0;
      end else begin
         rd_trk_reg[0] <= accept_rd;
         wr_trk_reg[0] <= accept_wr;
         rd_valid      <= 1'b0;
         if (accept_wr) begin
            wd0_reg <= cmd_wdata;
         end
         if (!cke_n_reg) begin
            rd_trk_reg[2:1] <= rd_trk_reg[1:0];
            wr_trk_reg[1]   <= wr_trk_reg[0];
            wd1_reg         <= wd0_reg;
            dq_oe_reg       <= ft_mode ? wr_trk_reg[0] : wr_trk_reg[1];
            dq_out_reg      <= ft_mode ? wd0_reg : wd1_reg;
            if (ft_mode ? rd_trk_reg[1] : rd_trk_reg[2]) begin
               rd_valid <= 1'b1;
               rd_data  <= link.dq;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         hpwr_reg     <= sram_link_pkg::H_RUN;
         cnt_reg      <= '0;
         sleep_active <= sram_link_pkg::SLEEP_PIN_DEFAULT;
         rd_ready     <= 1'b1;
         wr_ready     <= 1'b1;
      end else begin
         unique case (hpwr_reg)
            sram_link_pkg::H_RUN: begin
               if (sleep_req && !pins_float) begin
                  hpwr_reg <= sram_link_pkg::H_DRAIN;
                  rd_ready <= 1'b0;
                  wr_ready <= 1'b0;
               end
            end
            sram_link_pkg::H_DRAIN: begin
               if (empty && !accept) begin
                  hpwr_reg     <= sram_link_pkg::H_SLEEP;
                  sleep_active <= 1'b1;
               end
            end
            sram_link_pkg::H_SLEEP: begin
               if (!sleep_req) begin
                  hpwr_reg     <= sram_link_pkg::H_QUIET;
                  sleep_active <= 1'b0;
                  cnt_reg      <= QUIET_INIT;
               end
            end
            sram_link_pkg::H_QUIET: begin
               if (cnt_reg == '0) begin
                  hpwr_reg <= sram_link_pkg::H_RECOVER;
                  rd_ready <= 1'b1;
                  cnt_reg  <= RECOVER_INIT;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            sram_link_pkg::H_RECOVER: begin
               if (cnt_reg == '0) begin
                  hpwr_reg <= sram_link_pkg::H_RUN;
                  wr_ready <= 1'b1;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ft_pin_reg <= sram_link_pkg::FT_PIN_DEFAULT;
         pin_oe_reg <= 1'b0;
         order_reg  <= sram_link_pkg::ORDER_PIN_RESET;
      end else begin
         ft_pin_reg <= !flow_mode_sel;
         pin_oe_reg <= !pins_float;
         order_reg  <= order_interleaved;
      end
   end

   assign link.cke_n                = cke_n_reg;
   assign link.advance_load         = adv_reg;
   assign link.we_n                 = we_n_reg;
   assign link.ce1_n                = ce1_n_reg;
   assign link.ce2                  = 1'b1;
   assign link.ce3_n                = 1'b0;
   assign link.byte_we_n            = be_n_reg;
   assign link.addr                 = addr_reg;
   assign link.dq_host_out          = dq_out_reg;
   assign link.dq_host_oe           = dq_oe_reg;
   assign link.sleep_drive          = sleep_active;
   assign link.sleep_drive_oe       = pin_oe_reg;
   assign link.ft_drive             = ft_pin_reg;
   assign link.ft_drive_oe          = pin_oe_reg;
   assign link.burst_order_select_n = order_reg;
endmodule : sram_host_end
`default_nettype wire

/* test/sram_link_properties.sv */
// Checker for pin timing, sleep and pin defaults on the SRAM link.
`timescale 1ns/1ns
`default_nettype none
module sram_link_properties (
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic        cke_n,
   input wire logic        advance_load,
   input wire logic        we_n,
   input wire logic        ce1_n,
   input wire logic [35:0] dq_dev_out,
   input wire logic        dq_dev_oe,
   input wire logic        dq_host_oe,
   input wire logic        sleep_request,
   input wire logic        sleep_drive_oe,
   input wire logic        ft_drive_oe,
   input wire logic        flow_through_select_n
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   logic pipe;
   logic rd;
   logic wr;
   assign pipe = flow_through_select_n;
   assign rd = !cke_n && !advance_load && !ce1_n && we_n && !sleep_request;
   assign wr = !cke_n && !advance_load && !ce1_n && !we_n && !sleep_request;
   pipe_read_a: assert property (
      pipe [*3] ##0 rd ##1 !cke_n |-> ##1 dq_dev_oe) else $error("late pipelined read");
   flow_read_a: assert property (
      (!pipe) [*3] ##0 rd |-> ##1 dq_dev_oe) else $error("late flow-through read");
   pipe_write_a: assert property (
      pipe [*3] ##0 wr ##1 !cke_n |-> ##1 dq_host_oe) else $error("late write data");
   sleep_hiz_a: assert property (
      sleep_request [*4] |-> !dq_dev_oe) else $error("bus driven while asleep");
   sleep_drain_a: assert property (
      $rose(sleep_request) |-> !dq_host_oe) else $error("sleep raised with write pending");
   recover_no_write_a: assert property (
      $fell(sleep_request) |-> (we_n || ce1_n || advance_load) [*5])
      else $error("write during wake-up");
   bus_no_clash_a: assert property (
      !(dq_dev_oe && dq_host_oe)) else $error("both ends drive the data bus");
   stall_hold_a: assert property (
      cke_n && !sleep_request |=> $stable(dq_dev_oe) && $stable(dq_dev_out))
      else $error("stalled edge changed read output");
   mode_default_a: assert property (
      !ft_drive_oe |-> pipe) else $error("floating mode pin not pipelined");
   sleep_default_a: assert property (
      !sleep_drive_oe |-> !sleep_request) else $error("floating sleep pin not low");
   cover property (rd ##1 wr);
   cover property (sleep_request [*4]);
   cover property (cke_n && dq_dev_oe);
endmodule : sram_link_properties
`default_nettype wire

/* test/sync_sram_burst_sleep_ctrl_tb.sv */
// Self-checking bench joining the controller end and the SRAM end.
`timescale 1ns/1ns
`default_nettype none
module sync_sram_burst_sleep_ctrl_tb;
   typedef struct packed {logic ft; logic il; logic [1:0] st; logic [9:0] seq;} row_t;
   logic        clock = 1'b0, arst_n = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0;
   logic        cmd_continue = 1'b0, stall_req = 1'b0, sleep_req = 1'b0;
   logic        flow_mode_sel = 1'b0, order_interleaved = 1'b0, pins_float = 1'b0;
   logic        rd_ready, wr_ready, rd_valid, sleep_active, sleeping, pipelined;
   logic [7:0]  cmd_addr = 8'h00;
   logic [35:0] cmd_wdata = 36'h0_0000_0000;
   logic [35:0] rd_data;
   logic [7:0]  exp_q[$];
   logic [35:0] got_q[$];
   int          bad_count = 0, comparisons = 0;
   row_t        rows[4];

   sram_link_if link ();
   sram_dev_end i_sram_dev_end (.clock(clock), .arst_n(arst_n), .link(link.dev),
      .sleeping(sleeping), .pipelined(pipelined));
   sram_host_end i_sram_host_end (.clock(clock), .arst_n(arst_n), .link(link.host),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_continue(cmd_continue),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_byte_en(4'hf),
      .stall_req(stall_req), .sleep_req(sleep_req), .flow_mode_sel(flow_mode_sel),
      .order_interleaved(order_interleaved), .pins_float(pins_float), .rd_ready(rd_ready),
      .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid),
      .sleep_active(sleep_active));
   sram_link_properties i_sram_link_properties (.clock(clock), .arst_n(arst_n),
      .cke_n(link.cke_n), .advance_load(link.advance_load), .we_n(link.we_n),
      .ce1_n(link.ce1_n), .dq_dev_out(link.dq_dev_out), .dq_dev_oe(link.dq_dev_oe),
      .dq_host_oe(link.dq_host_oe), .sleep_request(link.sleep_request),
      .sleep_drive_oe(link.sleep_drive_oe), .ft_drive_oe(link.ft_drive_oe),
      .flow_through_select_n(link.flow_through_select_n));

   initial begin
      forever #2 clock = ~clock;
   end

   always @(posedge clock) begin
      if (rd_valid === 1'b1) got_q.push_back(rd_data);
   end

   function automatic logic [35:0] pat(input logic [7:0] a);
      return {4'h5, a, 24'h00_c3a5};
   endfunction : pat

   task automatic print_verdict();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   task automatic check_bit(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %s expected %b seen %b", what, exp, got);
      end
   endtask : check_bit

   task automatic check_word(input string what, input logic [35:0] exp, input logic [35:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   // Holds the command until the edge that takes it; returns on that edge.
   task automatic issue(input logic w, input logic c, input logic [7:0] a);
      logic ok;
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_continue <= c;
      cmd_addr <= a;
      cmd_wdata <= pat(a);
      if (!w) exp_q.push_back(a);
      for (int i = 0; i < 50; i++) begin
         @(negedge clock);
         ok = (w ? wr_ready : rd_ready) && !stall_req;
         @(posedge clock);
         if (ok) return;
      end
      bad_count++;
      print_verdict();
   endtask : issue

   task automatic idle(input int n);
      cmd_valid <= 1'b0;
      repeat (n) @(posedge clock);
   endtask : idle

   task automatic drain(input string name);
      for (int i = 0; i < 40 && got_q.size() < exp_q.size(); i++) @(posedge clock);
      if (got_q.size() != exp_q.size()) begin
         bad_count++;
         print_verdict();
      end
      while (exp_q.size() > 0) check_word("read data", pat(exp_q.pop_front()), got_q.pop_front());
      $display("%s test done", name);
   endtask : drain

   initial begin
      rows = '{14'h05b1, 14'h3539, 14'h2ac6, 14'h1f93};
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      @(negedge clock);
      check_bit("pipelined", 1'b1, pipelined);
      check_bit("sleeping", 1'b0, sleeping);
      check_bit("mode pin", 1'b1, link.flow_through_select_n);
      check_bit("sleep pin", 1'b0, link.sleep_request);
      $display("reset test done");
      @(posedge clock);
      for (int i = 0; i < 4; i++) issue(1'b1, i != 0, 8'h10 + 8'(i));
      for (int r = 0; r < 4; r++) begin
         flow_mode_sel <= rows[r].ft;
         order_interleaved <= rows[r].il;
         idle(8);
         for (int i = 0; i < 5; i++) issue(1'b0, i != 0, {6'h04, rows[r].seq[9-2*i -: 2]});
         idle(1);
         drain("burst row");
      end
      issue(1'b1, 1'b0, 8'h20);
      issue(1'b0, 1'b0, 8'h10);
      issue(1'b1, 1'b0, 8'h21);
      issue(1'b0, 1'b0, 8'h11);
      issue(1'b0, 1'b0, 8'h20);
      issue(1'b0, 1'b0, 8'h21);
      idle(1);
      drain("back to back");
      issue(1'b0, 1'b0, 8'h10);
      issue(1'b0, 1'b1, 8'h11);
      stall_req <= 1'b1;
      fork
         issue(1'b0, 1'b1, 8'h12);
         begin
            repeat (3) @(posedge clock);
            stall_req <= 1'b0;
         end
      join
      idle(1);
      drain("stall");
      sleep_req <= 1'b1;
      flow_mode_sel <= 1'b1;
      for (int i = 0; i < 12 && sleeping !== 1'b1; i++) @(negedge clock);
      check_bit("sleeping", 1'b1, sleeping);
      check_bit("bus released", 1'b0, link.dq_dev_oe);
      check_bit("sleep out", 1'b1, sleep_active);
      repeat (4) @(posedge clock);
      sleep_req <= 1'b0;
      issue(1'b1, 1'b0, 8'h22);
      issue(1'b0, 1'b0, 8'h13);
      idle(6);
      issue(1'b0, 1'b0, 8'h22);
      idle(1);
      drain("sleep");
      check_bit("awake", 1'b0, sleeping);
      check_bit("flow mode", 1'b0, pipelined);
      pins_float <= 1'b1;
      sleep_req <= 1'b1;
      idle(6);
      check_bit("float mode", 1'b1, pipelined);
      check_bit("float sleep", 1'b0, sleeping);
      issue(1'b0, 1'b0, 8'h13);
      idle(1);
      drain("float pins");
      print_verdict();
   end
endmodule : sync_sram_burst_sleep_ctrl_tb
`default_nettype wire
